// [rtl/dmcg_pkg.sv]
// Purpose: shared constants for the dual mode crc generator and checker
// Assumes: 200 MHz aclk, axi4-lite register access, 32-bit data
// Notes:   residues are held in logical sense, bit 15 most significant
package dmcg_pkg;
  localparam int          CLK_PERIOD_PS   = 5000;
  localparam int          CLR_PULSE_NS    = 100;
  localparam int          CLR_PULSE_CYC   =
    ((CLR_PULSE_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [4:0]  CLR_CNT_W_MAX   = 5'(CLR_PULSE_CYC);
  localparam logic [15:0] POLY_CRC16      = 16'h8005;
  localparam logic [15:0] POLY_CCITT      = 16'h1021;
  localparam logic [15:0] RESIDUE_BYTECNT = 16'h0000;
  localparam logic [15:0] RESIDUE_BITSTF  = 16'h1D0F;
  localparam logic [15:0] INIT_BYTECNT    = 16'h0000;
  localparam logic [15:0] INIT_BITSTF     = 16'hFFFF;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_MAINT      = 8'h04;
  localparam logic [7:0]  ADDR_IN_CTRL    = 8'h08;
  localparam logic [7:0]  ADDR_TX_CRC     = 8'h0C;
  localparam logic [7:0]  ADDR_RX_CRC     = 8'h10;
  localparam int          CTRL_SOM_BIT    = 0;
  localparam int          MAINT_MODE_BIT  = 0;
  localparam int          IN_MATCH_BIT    = 0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// [rtl/dmcg_crc_stage.sv]
// Purpose: one serial crc step for either polynomial
// Assumes: logical-sense values, bit 15 shifts out first
// Notes:   combinational, used by tx and rx registers
`timescale 1ns/1ps
module dmcg_crc_stage (
  input  wire logic [15:0] crc_in,
  input  wire logic        data_bit,
  input  wire logic        bitstuff,
  input  wire logic        feed_en,
  output logic      [15:0] crc_out
);
  logic [15:0] poly;
  logic        fb;

  assign poly = bitstuff ? dmcg_pkg::POLY_CCITT
                         : dmcg_pkg::POLY_CRC16;
  // input gate shared by both modes, gated off while check word goes out
  assign fb = feed_en & (data_bit ^ crc_in[15]);
  // taps not in poly just pass the previous stage
  assign crc_out = {crc_in[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
endmodule

// [rtl/dmcg_top.sv]
// Purpose: serial crc generator and residue checker with axi4-lite regs
// Assumes: tx/rx bit pulses and phase signals come from outside the clock
// Notes:   external line signals pass a two-stage synchroniser
// Summary of operation
// - sender appends check word after message
// - receiver accumulates data plus check word
// - byte-count mode: zero residue means good
// - bit-stuff mode: residue 016417 means good
// - bit-stuff mode inverts line level polarity
// - maintenance bit 0 selects bit-stuff mode
// - all sixteen residue bits must match
// - any mismatch drops the match flag
// - detect errors only, no correction
// - byte-count uses crc-16 taps 0,2,15
// - bit-stuff uses ccitt taps 0,5,12
// - unused taps pass previous stage unchanged
// - shift once per bit, only when enabled
// - start-of-message bit holds tx register cleared
// - no clear while check-word phase high (start-of-message bit still clears tx register then)
// - 100 ns clear on phase falling edge
// - byte-count tx register starts all zeros
// - bit-stuff registers start all logical ones
// - bit-stuff check word sent complemented
// - match result is input control bit 0
`timescale 1ns/1ps
module dmcg_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_bit_pulse,
  input  wire logic        crc_shift_enable,
  input  wire logic        send_check_word_phase,
  input  wire logic        tx_data_bit,
  input  wire logic        rx_bit_pulse,
  input  wire logic        rx_shift_enable,
  input  wire logic        rx_active,
  input  wire logic        rx_data_bit,
  output logic             tx_line_bit_ff,
  output logic             tx_crc_shift_clock_ff,
  output logic             residue_match_flag_ff,
  output logic             bitstuff_mode_select_ff
);
  // synchronisers for line signals: {txp, txen, scw, txd, rxp, rxen, act, rxd}
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [7:0] line_raw;
  assign line_raw = {tx_bit_pulse, crc_shift_enable, send_check_word_phase,
                     tx_data_bit, rx_bit_pulse, rx_shift_enable, rx_active,
                     rx_data_bit};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= line_raw;
      sync2_ff <= sync1_ff;
    end
  end

  logic txp_s, txen_s, scw_s, txd_s, rxp_s, rxen_s, act_s, rxd_s;
  assign {txp_s, txen_s, scw_s, txd_s, rxp_s, rxen_s, act_s, rxd_s} =
         sync2_ff;

  logic txp_d_ff, rxp_d_ff, scw_d_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txp_d_ff <= 1'b0;
      rxp_d_ff <= 1'b0;
      scw_d_ff <= 1'b0;
    end else begin
      txp_d_ff <= txp_s;
      rxp_d_ff <= rxp_s;
      scw_d_ff <= scw_s;
    end
  end

  wire tx_edge  = txp_s & ~txp_d_ff;
  wire rx_edge  = rxp_s & ~rxp_d_ff;
  wire scw_fall = scw_d_ff & ~scw_s;

  // software registers
  logic       som_ff;
  logic       mode_ff;
  logic [4:0] clr_cnt_ff;
  logic [4:0] nxt_clr_cnt;
  logic [15:0] tx_crc_ff;
  logic [15:0] rx_crc_ff;
  logic [15:0] nxt_tx_crc;
  logic [15:0] nxt_rx_crc;
  logic [15:0] tx_step;
  logic [15:0] rx_step;

  wire som_clear_request = som_ff;
  wire end_clear = (clr_cnt_ff != 5'h00);
  wire tx_clear  = som_clear_request | end_clear;
  wire [15:0] init_val = mode_ff ? dmcg_pkg::INIT_BITSTF
                                 : dmcg_pkg::INIT_BYTECNT;

  // falling edge starts the short clear; high phase keeps it idle
  assign nxt_clr_cnt = scw_fall ? dmcg_pkg::CLR_CNT_W_MAX
                     : (scw_s ? 5'h00
                     : (end_clear ? clr_cnt_ff - 5'h01 : 5'h00));

  wire tx_shift = tx_edge & txen_s;

  dmcg_crc_stage u_tx_stage (
    .crc_in   (tx_crc_ff),
    .data_bit (txd_s),
    .bitstuff (mode_ff),
    .feed_en  (~scw_s),
    .crc_out  (tx_step)
  );

  dmcg_crc_stage u_rx_stage (
    .crc_in   (rx_crc_ff),
    .data_bit (rxd_s),
    .bitstuff (mode_ff),
    .feed_en  (1'b1),
    .crc_out  (rx_step)
  );

  assign nxt_tx_crc = tx_clear ? init_val
                    : (tx_shift ? tx_step : tx_crc_ff);
  // receiver runs over data and received check word alike
  assign nxt_rx_crc = ~act_s ? init_val
                    : ((rx_edge & rxen_s) ? rx_step : rx_crc_ff);

  // send-phase output: data while accumulating, then register msb, complemented in bit-stuff mode
  wire tx_logic_bit = scw_s ? (mode_ff ? ~tx_crc_ff[15]
                                       : tx_crc_ff[15])
                            : txd_s;
  // bit-stuff line level is inverted
  wire tx_level = tx_logic_bit ^ mode_ff;

  wire [15:0] expect_res = mode_ff ? dmcg_pkg::RESIDUE_BITSTF
                                   : dmcg_pkg::RESIDUE_BYTECNT;
  // flag only, no correction attempted
  wire match = (rx_crc_ff == expect_res);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_cnt_ff            <= 5'h00;
      tx_crc_ff             <= 16'h0000;
      rx_crc_ff             <= 16'h0000;
      tx_line_bit_ff        <= 1'b0;
      tx_crc_shift_clock_ff <= 1'b0;
      residue_match_flag_ff <= 1'b0;
      bitstuff_mode_select_ff <= 1'b0;
    end else begin
      clr_cnt_ff            <= nxt_clr_cnt;
      tx_crc_ff             <= nxt_tx_crc;
      rx_crc_ff             <= nxt_rx_crc;
      tx_line_bit_ff        <= tx_level;
      tx_crc_shift_clock_ff <= tx_shift;
      residue_match_flag_ff <= match;
      bitstuff_mode_select_ff <= mode_ff;
    end
  end

  // axi4-lite write path
  logic        aw_got_ff, w_got_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  wire aw_hs   = s_axi_awvalid & s_axi_awready;
  wire w_hs    = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire wr_ctrl  = wr_fire & (aw_addr_ff == dmcg_pkg::ADDR_CTRL) &
                  w_strb_ff[0];
  wire wr_maint = wr_fire & (aw_addr_ff == dmcg_pkg::ADDR_MAINT) &
                  w_strb_ff[0];
  wire wr_known = (aw_addr_ff == dmcg_pkg::ADDR_CTRL) |
                  (aw_addr_ff == dmcg_pkg::ADDR_MAINT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h0000_0000;
      w_strb_ff     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dmcg_pkg::RESP_OKAY;
      som_ff        <= 1'b0;
      mode_ff       <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_got_ff & ~aw_hs & ~s_axi_bvalid;
      s_axi_wready  <= ~w_got_ff & ~w_hs & ~s_axi_bvalid;
      if (aw_hs) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? dmcg_pkg::RESP_OKAY
                                 : dmcg_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        som_ff <= w_data_ff[dmcg_pkg::CTRL_SOM_BIT];
      end
      if (wr_maint) begin
        mode_ff <= w_data_ff[dmcg_pkg::MAINT_MODE_BIT];
      end
    end
  end

  // axi4-lite read path
  logic [31:0] rd_mux;
  logic        rd_known;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  always_comb begin
    rd_mux   = 32'h0000_0000;
    rd_known = 1'b1;
    unique case (s_axi_araddr)
      dmcg_pkg::ADDR_CTRL:    rd_mux[dmcg_pkg::CTRL_SOM_BIT] = som_ff;
      dmcg_pkg::ADDR_MAINT:   rd_mux[dmcg_pkg::MAINT_MODE_BIT] = mode_ff;
      dmcg_pkg::ADDR_IN_CTRL:
        rd_mux[dmcg_pkg::IN_MATCH_BIT] = residue_match_flag_ff;
      dmcg_pkg::ADDR_TX_CRC:  rd_mux[15:0] = tx_crc_ff;
      dmcg_pkg::ADDR_RX_CRC:  rd_mux[15:0] = rx_crc_ff;
      default:                rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= dmcg_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_hs;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_known ? dmcg_pkg::RESP_OKAY
                                 : dmcg_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// [verification/dmcg_monitor.sv]
// Purpose: port assertions for dmcg_top
// Assumes: one aclk domain, sync low reset
// Notes:   bound to every dmcg_top
`timescale 1ns/1ps
module dmcg_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_bit_pulse,
  input wire logic crc_shift_enable,
  input wire logic rx_bit_pulse,
  input wire logic rx_active,
  input wire logic send_check_word_phase,
  input wire logic tx_data_bit,
  input wire logic tx_line_bit_ff,
  input wire logic tx_crc_shift_clock_ff,
  input wire logic residue_match_flag_ff,
  input wire logic bitstuff_mode_select_ff
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SHIFT_NEEDS_EN:
    assert property ((!crc_shift_enable)[*8] |-> !tx_crc_shift_clock_ff)
    else $error("tx shift without enable");
  AST_SHIFT_NEEDS_BIT:
    assert property ((!tx_bit_pulse)[*8] |-> !tx_crc_shift_clock_ff)
    else $error("tx shift without bit pulse");
  AST_SHIFT_SPACED:
    assert property (tx_crc_shift_clock_ff |=> (!tx_crc_shift_clock_ff)[*5])
    else $error("tx shift repeated within one bit");
  AST_SHIFT_AFTER_BIT:
    assert property ($rose(tx_bit_pulse) && crc_shift_enable
      |-> ##[1:5] tx_crc_shift_clock_ff) else $error("tx shift missing");
  AST_BYTECNT_INIT_OK:
    assert property ((!rx_active && !bitstuff_mode_select_ff)[*8]
      |-> residue_match_flag_ff) else $error("zero residue not matched");
  AST_BITSTF_INIT_BAD:
    assert property ((!rx_active && bitstuff_mode_select_ff)[*8]
      |-> !residue_match_flag_ff) else $error("all ones residue matched");
  AST_LINE_FOLLOWS_DATA:
    assert property ((!send_check_word_phase && $stable(tx_data_bit)
      && $stable(bitstuff_mode_select_ff))[*6]
      |-> tx_line_bit_ff == (tx_data_bit ^ bitstuff_mode_select_ff))
    else $error("line level wrong for data bit");
  AST_MATCH_STEADY:
    assert property ((rx_active && !rx_bit_pulse
      && $stable(bitstuff_mode_select_ff))[*8]
      |=> $stable(residue_match_flag_ff)) else $error("flag moved idle");
endmodule
bind dmcg_top dmcg_monitor u_mon (.*);

// [verification/dmcg_line_model.sv]
// Purpose: line control model, tx bit times and rx loopback
// Assumes: tx pulse is the 160 ns link clock, still between frames
// Notes:   bad flips every received bit
`timescale 1ns/1ps
module dmcg_line_model (
  input  wire logic aclk,
  input  wire logic mode,
  input  wire logic line_bit,
  output logic      tx_bit_pulse,
  output logic      crc_shift_enable,
  output logic      send_check_word_phase,
  output logic      tx_data_bit,
  output logic      rx_bit_pulse,
  output logic      rx_shift_enable,
  output logic      rx_active,
  output logic      rx_data_bit
);
  logic bad = 1'b0;
  // line level back to logical sense
  assign rx_data_bit = line_bit ^ mode ^ bad;
  initial begin
    {tx_bit_pulse, crc_shift_enable, send_check_word_phase} = 3'h0;
    {tx_data_bit, rx_bit_pulse, rx_shift_enable, rx_active} = 4'h0;
  end
  task automatic rx_on(input logic v);
    @(posedge aclk);
    rx_active <= v;
  endtask
  task automatic send(input logic [15:0] d, input logic ph);
    for (int i = 15; i >= 0; i--) begin
      @(posedge aclk);
      tx_data_bit <= d[i];
      crc_shift_enable <= 1'b1;
      rx_shift_enable <= 1'b1;
      send_check_word_phase <= ph;
      repeat (7) @(posedge aclk);
      rx_bit_pulse <= 1'b1;
      repeat (8) @(posedge aclk);
      rx_bit_pulse <= 1'b0;
      tx_bit_pulse <= 1'b1;
      repeat (16) @(posedge aclk);
      tx_bit_pulse <= 1'b0;
    end
    @(posedge aclk);
    {crc_shift_enable, rx_shift_enable, send_check_word_phase} <= 3'h0;
    tx_data_bit <= ~tx_data_bit;
  endtask
endmodule

// [verification/dual_mode_crc_gen_check_bench.sv]
// Purpose: self-checking bench for dmcg_top
// Assumes: line model loops the tx line back to rx
// Notes:   one task per scenario
`timescale 1ns/1ps
module dual_mode_crc_gen_check_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        tx_bit_pulse, crc_shift_enable, send_check_word_phase;
  logic        tx_data_bit, rx_bit_pulse, rx_shift_enable, rx_active;
  logic        rx_data_bit, tx_line_bit_ff, tx_crc_shift_clock_ff;
  logic        residue_match_flag_ff, bitstuff_mode_select_ff;
  logic [31:0] d;
  logic [1:0]  r;
  int          miscompares = 0;
  int          n_checks = 0;
  dmcg_top dut (.*);
  dmcg_line_model line (.mode(bitstuff_mode_select_ff),
    .line_bit(tx_line_bit_ff), .*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aok, wok;
    {aok, wok} = 2'h0;
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aok && wok)) begin
      @(posedge aclk);
      if (s_axi_awready) aok = 1'b1;
      if (s_axi_wready) wok = 1'b1;
      if (aok) s_axi_awvalid <= 1'b0;
      if (wok) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk("bresp", dmcg_pkg::RESP_OKAY, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [15:0] crc(logic [15:0] c, m, logic bs);
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ?
        (bs ? dmcg_pkg::POLY_CCITT : dmcg_pkg::POLY_CRC16) : 16'h0000);
    end
    return c;
  endfunction
  task automatic t_regs;
    rd(dmcg_pkg::ADDR_IN_CTRL);
    chk("match idle", 32'h1, d);
    rd(8'h14);
    chk("unmapped", {30'h0, dmcg_pkg::RESP_SLVERR}, {d[29:0], r});
  endtask
  task automatic t_frame(input logic bs, bad, input logic [15:0] m);
    logic [15:0] ini;
    ini = bs ? dmcg_pkg::INIT_BITSTF : dmcg_pkg::INIT_BYTECNT;
    wr(dmcg_pkg::ADDR_MAINT, {31'h0, bs});
    // mode mirror lands one edge after the write response
    @(posedge aclk);
    chk("mode", {31'h0, bs}, {31'h0, bitstuff_mode_select_ff});
    wr(dmcg_pkg::ADDR_CTRL, 32'h1);
    wr(dmcg_pkg::ADDR_CTRL, 32'h0);
    rd(dmcg_pkg::ADDR_TX_CRC);
    chk("tx start", {16'h0, ini}, d);
    line.bad = bad;
    line.rx_on(1'b1);
    line.send(m, 1'b0);
    rd(dmcg_pkg::ADDR_TX_CRC);
    chk("tx crc", {16'h0, crc(ini, m, bs)}, d);
    line.send(16'h0000, 1'b1);
    repeat (8) @(posedge aclk);
    chk("flag", {31'h0, !bad}, {31'h0, residue_match_flag_ff});
    rd(dmcg_pkg::ADDR_IN_CTRL);
    chk("in ctrl", {31'h0, !bad}, d);
    rd(dmcg_pkg::ADDR_TX_CRC);
    chk("tx cleared", {16'h0, ini}, d);
    line.rx_on(1'b0);
    line.bad = 1'b0;
  endtask
  task automatic t_som_hold;
    wr(dmcg_pkg::ADDR_CTRL, 32'h1);
    line.send(16'hFFFF, 1'b0);
    rd(dmcg_pkg::ADDR_TX_CRC);
    chk("som hold", 32'h0, d);
    wr(dmcg_pkg::ADDR_CTRL, 32'h0);
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200us;
    miscompares++;
    final_report;
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, s_axi_wstrb} = {32'h0, 4'hF};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_frame(1'b0, 1'b0, 16'hA5C3);
    t_frame(1'b1, 1'b0, 16'h3C5A);
    t_frame(1'b0, 1'b1, 16'hA5C3);
    t_som_hold;
    final_report;
  end
endmodule
